// File: hw/mdsr_status_bank.sv
/*
  status register bank: fault flags, ripple counter, speed, voltage and current
  codes, with the open-drain fault pin. assumes fault detectors, ripple pulse
  and analog codes come from on-chip logic in the same clock domain, except the
  supply-good level which arrives asynchronously and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module mdsr_status_bank
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // fault detectors, same domain
  input  wire logic                          stallEvent,
  input  wire logic                          overcurrentEvent,
  input  wire logic                          overvoltageEvent,
  input  wire logic                          thermalEvent,
  // supply above undervoltage_threshold, asynchronous level
  input  wire logic                          supplyGood,
  // command bits written by the host into the control register
  input  wire logic                          clearFaultsCmd,
  input  wire logic                          clearCountCmd,
  // ripple counting and measurement
  input  wire logic                          ripplePulse,
  input  wire logic [mdsr_pkg::THR_W-1:0]    rippleThreshold,
  input  wire logic [mdsr_pkg::DATA_W-1:0]   speedEstimate,
  input  wire logic [mdsr_pkg::DATA_W-1:0]   motorVoltage,
  input  wire logic [mdsr_pkg::DATA_W-1:0]   motorCurrent,
  // register port
  input  wire logic [mdsr_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic                          regWrite,
  input  wire logic [mdsr_pkg::DATA_W-1:0]   regWdata,
  output var  logic [mdsr_pkg::DATA_W-1:0]   regRdata,
  // command self-clear acknowledges
  output var  logic                          clearFaultsDone,
  output var  logic                          clearCountDone,
  // open-drain fault pin
  output var  logic                          faultOutN,
  output var  logic                          faultOutOe,
  // ripple count for downstream logic
  output var  logic [mdsr_pkg::COUNT_W-1:0]  rippleCount
);

  logic [mdsr_pkg::SYNC_STAGES-1:0] supplySync_reg;
  logic                             supplyLevel_reg;
  logic                             stallFlag_reg;
  logic                             overcurrentFlag_reg;
  logic                             overvoltageFlag_reg;
  logic                             thermalFlag_reg;
  logic                             powerOnLatch_reg;
  logic                             countReachedFlag_reg;
  logic [mdsr_pkg::COUNT_W-1:0]     rippleCount_reg;
  logic [mdsr_pkg::COUNT_W-1:0]     rippleCount_next;
  logic                             anyFault;
  logic [mdsr_pkg::DATA_W-1:0]      faultStatus;
  logic [mdsr_pkg::DATA_W-1:0]      regRdata_next;

  // supply level: change accepted once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      supplySync_reg  <= '0;
      supplyLevel_reg <= 1'b0;
    end
    else
    begin
      supplySync_reg <= {supplySync_reg[1:0], supplyGood};
      if (supplySync_reg[1] == supplySync_reg[2])
      begin
        supplyLevel_reg <= supplySync_reg[2];
      end
    end
  end

  // latched faults; a new event wins over the clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stallFlag_reg       <= 1'b0;
      overcurrentFlag_reg <= 1'b0;
      overvoltageFlag_reg <= 1'b0;
      thermalFlag_reg     <= 1'b0;
    end
    else
    begin
      stallFlag_reg       <= stallEvent | (stallFlag_reg & ~clearFaultsCmd);
      overcurrentFlag_reg <= overcurrentEvent | (overcurrentFlag_reg & ~clearFaultsCmd);
      overvoltageFlag_reg <= overvoltageEvent | (overvoltageFlag_reg & ~clearFaultsCmd);
      thermalFlag_reg     <= thermalEvent | (thermalFlag_reg & ~clearFaultsCmd);
    end
  end

  // power-on latch: low while supply is below threshold, set by clear-faults
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      powerOnLatch_reg <= 1'b0;
    end
    else if (!supplyLevel_reg)
    begin
      powerOnLatch_reg <= 1'b0;
    end
    else if (clearFaultsCmd)
    begin
      powerOnLatch_reg <= 1'b1;
    end
  end

  // ripple counter; clear-count restarts from zero, saturates at the top
  always_comb
  begin
    rippleCount_next = rippleCount_reg;
    if (clearCountCmd)
    begin
      rippleCount_next = mdsr_pkg::RST_COUNT;
    end
    else if (ripplePulse && (rippleCount_reg != '1))
    begin
      rippleCount_next = rippleCount_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rippleCount_reg <= mdsr_pkg::RST_COUNT;
    end
    else
    begin
      rippleCount_reg <= rippleCount_next;
    end
  end

  // count-reached flag holds until clear-count; a pulse in that cycle is dropped, so the clear always wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      countReachedFlag_reg <= 1'b0;
    end
    else if (rippleCount_next > {6'h00, rippleThreshold})
    begin
      countReachedFlag_reg <= 1'b1;
    end
    else if (clearCountCmd)
    begin
      countReachedFlag_reg <= 1'b0;
    end
  end

  // summary covers the protection faults; the power-on latch is a status, not a fault
  assign anyFault = stallFlag_reg | overcurrentFlag_reg | overvoltageFlag_reg
                  | thermalFlag_reg;

  always_comb
  begin
    faultStatus                         = mdsr_pkg::RST_STATUS;
    faultStatus[mdsr_pkg::BIT_SUMMARY]  = anyFault;
    faultStatus[mdsr_pkg::BIT_RSVD]     = 1'b0;
    faultStatus[mdsr_pkg::BIT_STALL]    = stallFlag_reg;
    faultStatus[mdsr_pkg::BIT_OVERCUR]  = overcurrentFlag_reg;
    faultStatus[mdsr_pkg::BIT_OVERVOLT] = overvoltageFlag_reg;
    faultStatus[mdsr_pkg::BIT_THERMAL]  = thermalFlag_reg;
    faultStatus[mdsr_pkg::BIT_POWERON]  = powerOnLatch_reg;
    faultStatus[mdsr_pkg::BIT_CNTDONE]  = countReachedFlag_reg;
  end

  // read mux; writes are ignored, regWdata is not looked at
  always_comb
  begin
    case (regAddr)
      mdsr_pkg::OFS_FAULT:    regRdata_next = faultStatus;
      mdsr_pkg::OFS_SPEED:    regRdata_next = speedEstimate;
      mdsr_pkg::OFS_CNT_LOW:  regRdata_next = rippleCount_reg[7:0];
      mdsr_pkg::OFS_CNT_HIGH: regRdata_next = rippleCount_reg[15:8];
      mdsr_pkg::OFS_VOLTAGE:  regRdata_next = motorVoltage;
      mdsr_pkg::OFS_CURRENT:  regRdata_next = motorCurrent;
      default:                regRdata_next = mdsr_pkg::RST_STATUS;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regRdata <= mdsr_pkg::RST_STATUS;
    end
    else
    begin
      regRdata <= regRdata_next;
    end
  end

  // output pin and command acknowledges, all from flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      faultOutN       <= 1'b1;
      faultOutOe      <= 1'b0;
      clearFaultsDone <= 1'b0;
      clearCountDone  <= 1'b0;
      rippleCount     <= mdsr_pkg::RST_COUNT;
    end
    else
    begin
      faultOutN       <= 1'b0;
      faultOutOe      <= anyFault;
      clearFaultsDone <= clearFaultsCmd;
      clearCountDone  <= clearCountCmd;
      rippleCount     <= rippleCount_next;
    end
  end

  // assertions
  a_summary_tracks_flags: assert property (@(posedge clk) disable iff (rst)
    (regAddr == mdsr_pkg::OFS_FAULT) |=> (regRdata[mdsr_pkg::BIT_SUMMARY] ==
      $past(stallFlag_reg | overcurrentFlag_reg | overvoltageFlag_reg | thermalFlag_reg)))
    else $error("fault summary read disagrees with individual flags");

  a_pin_follows_fault: assert property (@(posedge clk) disable iff (rst)
    anyFault |=> (faultOutOe && !faultOutN))
    else $error("fault pin not pulled low one cycle after fault");

  a_stall_latched: assert property (@(posedge clk) disable iff (rst)
    stallEvent |=> stallFlag_reg)
    else $error("stall event did not set stall flag");

  a_faults_cleared: assert property (@(posedge clk) disable iff (rst)
    (clearFaultsCmd && !overcurrentEvent && !thermalEvent) |=>
      (!overcurrentFlag_reg && !thermalFlag_reg))
    else $error("clear-faults left a flag set");

  a_overvolt_set: assert property (@(posedge clk) disable iff (rst)
    overvoltageEvent |=> overvoltageFlag_reg ##1 (overvoltageFlag_reg || $past(clearFaultsCmd)))
    else $error("overvoltage flag not held");

  a_poweron_low: assert property (@(posedge clk) disable iff (rst)
    !supplyLevel_reg |=> !powerOnLatch_reg)
    else $error("power-on latch high while supply low");

  a_poweron_set: assert property (@(posedge clk) disable iff (rst)
    (supplyLevel_reg && clearFaultsCmd) |=> powerOnLatch_reg)
    else $error("power-on latch not set by clear-faults");

  a_count_done_hold: assert property (@(posedge clk) disable iff (rst)
    (countReachedFlag_reg && !clearCountCmd) |=> countReachedFlag_reg)
    else $error("count-reached flag dropped without clear-count");

  a_count_cleared: assert property (@(posedge clk) disable iff (rst)
    clearCountCmd |=> (rippleCount_reg == mdsr_pkg::RST_COUNT))
    else $error("clear-count did not zero the ripple counter");

  a_read_count_high: assert property (@(posedge clk) disable iff (rst)
    (regAddr == mdsr_pkg::OFS_CNT_HIGH && !clearCountCmd && !ripplePulse) |=>
      (regRdata == rippleCount_reg[15:8]))
    else $error("count-high read mismatch");

  a_pin_released: assert property (@(posedge clk) disable iff (rst)
    !anyFault |=> !faultOutOe)
    else $error("fault pin not released one cycle after faults cleared");

  a_overcur_latched: assert property (@(posedge clk) disable iff (rst)
    overcurrentEvent |=> overcurrentFlag_reg)
    else $error("overcurrent event did not set its flag");

  a_thermal_latched: assert property (@(posedge clk) disable iff (rst)
    thermalEvent |=> thermalFlag_reg)
    else $error("thermal event did not set its flag");

  a_count_reached_set: assert property (@(posedge clk) disable iff (rst)
    (ripplePulse && !clearCountCmd && (rippleCount_reg == {6'h00, rippleThreshold}))
      |=> countReachedFlag_reg)
    else $error("count-reached flag not set when the count passed the threshold");

  a_count_increments: assert property (@(posedge clk) disable iff (rst)
    (ripplePulse && !clearCountCmd && (rippleCount_reg != '1)) |=>
      (rippleCount_reg == $past(rippleCount_reg) + 16'h0001))
    else $error("ripple pulse did not advance the counter");

  a_count_flag_cleared: assert property (@(posedge clk) disable iff (rst)
    clearCountCmd |=> !countReachedFlag_reg)
    else $error("clear-count left the count-reached flag set");

  a_read_speed: assert property (@(posedge clk) disable iff (rst)
    (regAddr == mdsr_pkg::OFS_SPEED) |=> (regRdata == $past(speedEstimate)))
    else $error("speed read mismatch");

  a_read_voltage: assert property (@(posedge clk) disable iff (rst)
    (regAddr == mdsr_pkg::OFS_VOLTAGE) |=> (regRdata == $past(motorVoltage)))
    else $error("motor voltage read mismatch");

  a_read_current: assert property (@(posedge clk) disable iff (rst)
    (regAddr == mdsr_pkg::OFS_CURRENT) |=> (regRdata == $past(motorCurrent)))
    else $error("motor current read mismatch");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (regAddr == mdsr_pkg::OFS_FAULT) |=> !regRdata[mdsr_pkg::BIT_RSVD])
    else $error("reserved fault bit read as one");

  a_writes_ignored: assert property (@(posedge clk) disable iff (rst)
    (regWrite && !clearFaultsCmd && !clearCountCmd && !ripplePulse && !stallEvent
      && !overcurrentEvent && !overvoltageEvent && !thermalEvent) |=>
      $stable({stallFlag_reg, overcurrentFlag_reg, overvoltageFlag_reg, thermalFlag_reg,
               countReachedFlag_reg, rippleCount_reg}))
    else $error("host write changed status state");

endmodule // mdsr_status_bank
`default_nettype wire

// File: inc/mdsr_pkg.sv
/*
  constants for the motor driver status register bank: offsets, field positions,
  reset values and widths. assumes the serial control front end supplies a read
  address and write strobes in the core clock domain.
*/
// How it works
// - fault summary bit 7 is 1 while any fault condition exists, else 0.
// - active-low fault pin pulled low whenever the summary flag is 1.
// - bit 5 set to 1 indicates the motor has stalled.
// - overcurrent flag in bit 4 set on an overcurrent event, else 0.
// - overvoltage flag in bit 3 set on an overvoltage event, else 0.
// - thermal shutdown flag in bit 2 set on a thermal event, else 0.
// - power-on latch bit 1 cleared and held low while supply is below undervoltage threshold.
// - power-on latch stays low until clear-faults, then goes high.
// - count-reached flag bit 0 latches high when ripple count exceeds threshold.
// - count-reached flag stays set until a clear-count command clears it.
// - speed register bits 7..0 show the estimated motor speed, read only.
// - 16-bit ripple counter, low byte exposed in count-low register.
// - upper byte of the ripple counter exposed in count-high register.
// - motor voltage 8-bit code, 00h is 0 V, B0h is 11 V, max FFh.
// - motor current 8-bit code, 00h is 0 A, C0h is gain-selected full scale.
// - clear-faults command clears latched faults and self-clears to 0.
// - clear-count resets counter, clears count-reached flag, self-clears.
package mdsr_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam int          COUNT_W        = 16;
  localparam int          THR_W          = 10;
  localparam logic [7:0]  OFS_FAULT      = 8'h00;
  localparam logic [7:0]  OFS_SPEED      = 8'h01;
  localparam logic [7:0]  OFS_CNT_LOW    = 8'h02;
  localparam logic [7:0]  OFS_CNT_HIGH   = 8'h03;
  localparam logic [7:0]  OFS_VOLTAGE    = 8'h04;
  localparam logic [7:0]  OFS_CURRENT    = 8'h05;
  localparam int          BIT_SUMMARY    = 7;
  localparam int          BIT_RSVD       = 6;
  localparam int          BIT_STALL      = 5;
  localparam int          BIT_OVERCUR    = 4;
  localparam int          BIT_OVERVOLT   = 3;
  localparam int          BIT_THERMAL    = 2;
  localparam int          BIT_POWERON    = 1;
  localparam int          BIT_CNTDONE    = 0;
  localparam logic [7:0]  RST_STATUS     = 8'h00;
  localparam logic [15:0] RST_COUNT      = 16'h0000;
  localparam logic [7:0]  VOLT_CODE_11V  = 8'hb0;
  localparam logic [7:0]  CUR_CODE_FULL  = 8'hc0;
  localparam int          SYNC_STAGES    = 3;
endpackage

// File: sim/mdsr_host_model.sv
/*
  host side model: drives the register port and the command pulses.
  assumes commands reach the bank as one-cycle pulses from the control register.
*/
`timescale 1ns/1ps
`default_nettype none
module mdsr_host_model
(
  // clock
  input  wire logic       clk,
  // register port
  output var  logic [7:0] regAddr,
  output var  logic       regWrite,
  output var  logic [7:0] regWdata,
  input  wire logic [7:0] regRdata,
  // commands
  output var  logic       clearFaultsCmd,
  output var  logic       clearCountCmd
);
  initial
  begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    clearFaultsCmd = 1'b0;
    clearCountCmd = 1'b0;
  end
  // data is taken two edges on: the registered answer lands after the first
  task automatic readReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) regAddr <= a;
    @(posedge clk);
    @(posedge clk) d = regRdata;
  endtask
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk)
    begin
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
    end
    @(posedge clk) regWrite <= 1'b0;
  endtask
  task automatic clearFaults();
    @(posedge clk) clearFaultsCmd <= 1'b1;
    @(posedge clk) clearFaultsCmd <= 1'b0;
  endtask
  task automatic clearCount();
    @(posedge clk) clearCountCmd <= 1'b1;
    @(posedge clk) clearCountCmd <= 1'b0;
  endtask
endmodule // mdsr_host_model
`default_nettype wire

// File: sim/test_mdsr_status_bank.sv
/*
  self-checking bench for the status bank, host model on the register port.
  assumes the bank alone, one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_mdsr_status_bank;
  logic clk = 1'b0, rst = 1'b1, supplyGood = 1'b0, ripplePulse = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [9:0] rippleThreshold = 10'h003;
  logic [7:0] speedEstimate = 8'h00, motorVoltage = 8'h00, motorCurrent = 8'h00;
  logic [7:0] regAddr, regWdata, regRdata, rd;
  logic regWrite, clearFaultsCmd, clearCountCmd, clearFaultsDone, clearCountDone;
  logic faultOutN, faultOutOe;
  logic [15:0] rippleCount;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  always #10 clk = ~clk;
  mdsr_status_bank dut (.clk(clk), .rst(rst), .stallEvent(ev[0]), .overcurrentEvent(ev[1]),
    .overvoltageEvent(ev[2]), .thermalEvent(ev[3]), .supplyGood(supplyGood),
    .clearFaultsCmd(clearFaultsCmd), .clearCountCmd(clearCountCmd),
    .ripplePulse(ripplePulse), .rippleThreshold(rippleThreshold),
    .speedEstimate(speedEstimate), .motorVoltage(motorVoltage), .motorCurrent(motorCurrent),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .clearFaultsDone(clearFaultsDone), .clearCountDone(clearCountDone),
    .faultOutN(faultOutN), .faultOutOe(faultOutOe), .rippleCount(rippleCount));
  mdsr_host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .clearFaultsCmd(clearFaultsCmd),
    .clearCountCmd(clearCountCmd));
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check1(input string what, input logic e, input logic g);
    check8(what, {7'h00, e}, {7'h00, g});
  endtask
  task automatic readCheck(input logic [7:0] a, input logic [7:0] e);
    host.readReg(a, rd);
    check8("register read", e, rd);
  endtask
  task automatic pulseRipple(input int n);
    repeat (n)
    begin
      @(posedge clk) ripplePulse <= 1'b1;
      @(posedge clk) ripplePulse <= 1'b0;
    end
  endtask
  task automatic testReset();
    for (int a = 0; a < 7; a++)
      readCheck(a[7:0], 8'h00);
    host.writeReg(mdsr_pkg::OFS_FAULT, 8'hff);
    readCheck(mdsr_pkg::OFS_FAULT, 8'h00);
    check1("fault pin enable", 1'b0, faultOutOe);
    $display("test reset done");
  endtask
  task automatic testPowerOn();
    @(posedge clk) supplyGood <= 1'b1;
    repeat (10) @(posedge clk);
    readCheck(mdsr_pkg::OFS_FAULT, 8'h00);
    $display("test power-on done");
  endtask
  // reset in mid-run drops latched flags and the power-on latch
  task automatic testMidReset();
    @(posedge clk) ev[1] <= 1'b1;
    @(posedge clk)
    begin
      ev[1] <= 1'b0;
      rst <= 1'b1;
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check1("fault pin enable", 1'b0, faultOutOe);
    readCheck(mdsr_pkg::OFS_FAULT, 8'h00);
    readCheck(mdsr_pkg::OFS_CNT_LOW, 8'h00);
    $display("test mid reset done");
  endtask
  // first clear also raises the power-on latch, so later flags carry bit 1
  task automatic testFaults();
    logic [7:0] por;
    por = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) ev[i] <= 1'b1;
      @(posedge clk) ev[i] <= 1'b0;
      repeat (2) @(posedge clk);
      check1("fault pin enable", 1'b1, faultOutOe);
      check1("fault pin level", 1'b0, faultOutN);
      readCheck(mdsr_pkg::OFS_FAULT, 8'h80 | (8'h20 >> i) | por);
      host.clearFaults();
      @(negedge clk) check1("clear faults done", 1'b1, clearFaultsDone);
      por = 8'h02;
      readCheck(mdsr_pkg::OFS_FAULT, por);
      check1("fault pin enable", 1'b0, faultOutOe);
    end
    $display("test faults done");
  endtask
  task automatic testCount();
    pulseRipple(3);
    readCheck(mdsr_pkg::OFS_FAULT, 8'h02);
    pulseRipple(257);
    readCheck(mdsr_pkg::OFS_FAULT, 8'h03);
    readCheck(mdsr_pkg::OFS_CNT_LOW, 8'h04);
    readCheck(mdsr_pkg::OFS_CNT_HIGH, 8'h01);
    check8("ripple count low", 8'h04, rippleCount[7:0]);
    check8("ripple count high", 8'h01, rippleCount[15:8]);
    host.clearCount();
    @(negedge clk) check1("clear count done", 1'b1, clearCountDone);
    readCheck(mdsr_pkg::OFS_FAULT, 8'h02);
    readCheck(mdsr_pkg::OFS_CNT_LOW, 8'h00);
    readCheck(mdsr_pkg::OFS_CNT_HIGH, 8'h00);
    $display("test count done");
  endtask
  task automatic testCodes();
    logic [7:0] v [3] = '{mdsr_pkg::VOLT_CODE_11V, mdsr_pkg::CUR_CODE_FULL, 8'hff};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk)
      begin
        speedEstimate <= v[i];
        motorVoltage <= v[(i + 1) % 3];
        motorCurrent <= v[(i + 2) % 3];
      end
      readCheck(mdsr_pkg::OFS_SPEED, v[i]);
      readCheck(mdsr_pkg::OFS_VOLTAGE, v[(i + 1) % 3]);
      readCheck(mdsr_pkg::OFS_CURRENT, v[(i + 2) % 3]);
    end
    $display("test codes done");
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // whole sequence needs well under 3000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testPowerOn();
    testFaults();
    testCount();
    testCodes();
    testMidReset();
    conclude();
  end
endmodule // test_mdsr_status_bank
`default_nettype wire
